// ---- srs_status.sv ----
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) Event enable mask is eight bits wide
// (R2) Event summary is OR of enabled events
// (R3) Event query returns contents, then clears all but bits set in that cycle
// (R4) Operation complete flag set after pending work
// (R5) Completion query answers ASCII one when idle
// (R6) Master summary ORs enabled status byte bits
// (R7) Status read returns summary, never clears
// (R8) Clear status drops error; newline empties queue
// (R9) Bit seven mirrors operation status summary
// (R10) Message available while queue holds data
// (R11) Power on sets event bit seven
// (R12) Syntax error sets event bit five
// (R13) Range error sets event bit four
// (R14) Full error queue sets event bit three
// (R15) Empty read or loss sets bit two
// (R16) Save stores state; recall restores slot
// (R17) Identity query answers comma separated string
// (R18) Unused status and event bits read zero
module srs_status #(
    parameter int SLOTS = 16,
    parameter int STATE_W = 32,
    parameter int IDW = 64
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire srs_pkg::srs_cmd_e cmd_code,
    input wire logic [7:0] cmd_arg,
    input wire logic cmd_nl,
    input wire logic pending_busy,
    input wire logic oper_summary,
    input wire logic syntax_err,
    input wire logic exec_err,
    input wire logic err_queue_full,
    input wire logic out_read_empty,
    input wire logic out_lost,
    input wire logic err_present,
    input wire logic out_queue_nonempty,
    input wire logic [STATE_W-1:0] inst_state,
    input wire logic [IDW-1:0] ident_mfr,
    input wire logic [IDW-1:0] ident_model,
    input wire logic [IDW-1:0] ident_serial,
    input wire logic [IDW-1:0] ident_fw,
    output logic err_clear,
    output logic out_queue_flush,
    output logic resp_valid,
    output logic [7:0] resp_byte,
    output logic ident_valid,
    output logic [4*IDW+23:0] ident_str,
    output logic recall_valid,
    output logic [STATE_W-1:0] recall_state,
    output logic [7:0] status_byte,
    output logic srq
);

    localparam int SW = $clog2(SLOTS);
    localparam int IDLEN = 4 * IDW + 24;
    localparam logic [7:0] ID_SEP = 8'h2C;

    // The slot index is cut from the eight-bit argument: more than 256 slots cannot be reached
    initial begin
        if (SLOTS < 2 || SLOTS > 256) begin
            $error("srs_status: SLOTS must lie between 2 and 256");
        end
        if (STATE_W < 1) begin
            $error("srs_status: STATE_W must be at least 1");
        end
        if (IDW < 8 || IDW % 8 != 0) begin
            $error("srs_status: IDW must be a whole number of bytes");
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // All state of the block, registered as one word
    typedef struct packed {
        logic [7:0] events;
        logic [7:0] ev_mask;
        logic [7:0] sr_mask;
        srs_pkg::srs_opc_e opc;
        // Answer strobes and the data they carry
        logic err_clear;
        logic flush;
        logic resp_valid;
        logic [7:0] resp_byte;
        logic ident_valid;
        logic [IDLEN-1:0] ident_str;
        logic recall_valid;
        logic [STATE_W-1:0] recall_state;
        // Saved instrument states, one word per slot
        logic [SLOTS-1:0][STATE_W-1:0] mem;
    } srs_state_s;

    srs_state_s st_r;
    srs_state_s st_nxt;
    logic [7:0] sb;

    ////////////////////////////////////////////////////////////////////////

    // Status summary byte; bit 6 is left out of its own OR so it cannot hold itself up
    function automatic logic [7:0] status_of(
        input logic [7:0] ev,
        input logic [7:0] evm,
        input logic [7:0] srm,
        input logic oss,
        input logic mav
    );
        logic [7:0] s;
        s = 8'h00;
        s[srs_pkg::SB_OSS] = oss; // R9
        s[srs_pkg::SB_MAV] = mav; // R10
        s[srs_pkg::SB_ESB] = |(ev & evm & srs_pkg::EV_IMPL_MASK); // R2
        s[srs_pkg::SB_MSS] = |(s & srm & srs_pkg::SB_IMPL_MASK & ~8'h40); // R6
        return s & srs_pkg::SB_IMPL_MASK; // R18
    endfunction

    // Event bits raised by the command interface in this cycle
    function automatic logic [7:0] hw_events(
        input logic cme,
        input logic exe,
        input logic dde,
        input logic qye
    );
        logic [7:0] h;
        h = 8'h00;
        h[srs_pkg::EV_CME] = cme; // R12
        h[srs_pkg::EV_EXE] = exe; // R13
        h[srs_pkg::EV_DDE] = dde; // R14
        h[srs_pkg::EV_QYE] = qye; // R15
        return h;
    endfunction

    // The merge comes last, so a set wins over a read-clear in the same cycle
    function automatic logic [7:0] events_next(
        input logic [7:0] held,
        input logic [7:0] raised
    );
        return (held | raised) & srs_pkg::EV_IMPL_MASK; // R18
    endfunction

    // Identity answer: four fields joined by commas, first field in the top bytes
    function automatic logic [IDLEN-1:0] ident_join(
        input logic [IDW-1:0] mfr,
        input logic [IDW-1:0] model,
        input logic [IDW-1:0] serial,
        input logic [IDW-1:0] fw
    );
        return {mfr, ID_SEP, model, ID_SEP, serial, ID_SEP, fw}; // R17
    endfunction

    // Save and recall slot from the low argument bits
    function automatic logic [SW-1:0] slot_of(input logic [7:0] arg);
        return arg[SW-1:0];
    endfunction

    // Slots past the end of the memory are ignored rather than wrapped
    function automatic logic slot_ok(input logic [7:0] arg);
        return {24'h00_0000, arg} < SLOTS;
    endfunction

    assign sb = status_of(st_r.events, st_r.ev_mask, st_r.sr_mask, oper_summary,
                          out_queue_nonempty);

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [7:0] hw_set;
        logic [SW-1:0] slot;
        hw_set = hw_events(syntax_err, exec_err, err_queue_full, out_read_empty | out_lost);
        slot = slot_of(cmd_arg);
        st_nxt = st_r;
        // Answer strobes last one cycle unless a command raises them again
        st_nxt.err_clear = 1'b0;
        st_nxt.flush = 1'b0;
        st_nxt.resp_valid = 1'b0;
        st_nxt.ident_valid = 1'b0;
        st_nxt.recall_valid = 1'b0;
        // A completion wait ends in the first cycle with nothing pending
        case (st_r.opc)
            srs_pkg::SRS_OPC_FLAG: begin
                if (!pending_busy) begin
                    hw_set[srs_pkg::EV_OPC] = 1'b1; // R4
                    st_nxt.opc = srs_pkg::SRS_OPC_IDLE;
                end
            end
            srs_pkg::SRS_OPC_QUERY: begin
                if (!pending_busy) begin
                    st_nxt.resp_valid = 1'b1; // R5
                    st_nxt.resp_byte = srs_pkg::ASCII_ONE; // R5
                    st_nxt.opc = srs_pkg::SRS_OPC_IDLE;
                end
            end
            default: begin
            end
        endcase
        // One common command per cycle; unknown codes change nothing
        if (cmd_valid) begin
            case (cmd_code)
                srs_pkg::SRS_CMD_CLS: begin
                    st_nxt.err_clear = 1'b1; // R8
                    st_nxt.flush = cmd_nl; // R8
                end
                srs_pkg::SRS_CMD_EVM_WR: begin
                    st_nxt.ev_mask = cmd_arg; // R1
                end
                srs_pkg::SRS_CMD_EVM_RD: begin
                    st_nxt.resp_valid = 1'b1; // R1
                    st_nxt.resp_byte = st_r.ev_mask;
                end
                srs_pkg::SRS_CMD_ESR_RD: begin
                    st_nxt.resp_valid = 1'b1; // R3
                    st_nxt.resp_byte = st_r.events & srs_pkg::EV_IMPL_MASK; // R3
                    st_nxt.events = 8'h00; // R3
                end
                srs_pkg::SRS_CMD_IDN_RD: begin
                    st_nxt.ident_valid = 1'b1; // R17
                    st_nxt.ident_str = ident_join(ident_mfr, ident_model, ident_serial, ident_fw);
                end
                srs_pkg::SRS_CMD_OPC: begin
                    // A second wait request is ignored while one is open
                    if (st_r.opc == srs_pkg::SRS_OPC_IDLE) begin
                        st_nxt.opc = srs_pkg::SRS_OPC_FLAG; // R4
                    end
                end
                srs_pkg::SRS_CMD_OPC_RD: begin
                    if (st_r.opc == srs_pkg::SRS_OPC_IDLE) begin
                        st_nxt.opc = srs_pkg::SRS_OPC_QUERY; // R5
                    end
                end
                srs_pkg::SRS_CMD_SAV: begin
                    if (slot_ok(cmd_arg)) begin
                        st_nxt.mem[slot] = inst_state; // R16
                    end
                end
                srs_pkg::SRS_CMD_RCL: begin
                    if (slot_ok(cmd_arg)) begin
                        st_nxt.recall_valid = 1'b1; // R16
                        st_nxt.recall_state = st_r.mem[slot]; // R16
                    end
                end
                srs_pkg::SRS_CMD_SQM_WR: begin
                    st_nxt.sr_mask = cmd_arg; // R6
                end
                srs_pkg::SRS_CMD_SQM_RD: begin
                    st_nxt.resp_valid = 1'b1; // R6
                    st_nxt.resp_byte = st_r.sr_mask;
                end
                srs_pkg::SRS_CMD_STB_RD: begin
                    // The read leaves every status bit to its own cause
                    st_nxt.resp_valid = 1'b1; // R7
                    st_nxt.resp_byte = sb; // R7
                end
                default: begin
                end
            endcase
        end
        st_nxt.events = events_next(st_nxt.events, hw_set); // R18
    end

    ////////////////////////////////////////////////////////////////////////

    // The reset value marks the restart in the event flags
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
            st_r.events <= srs_pkg::EV_RESET; // R11
            st_r.ev_mask <= srs_pkg::MASK_RESET;
            st_r.sr_mask <= srs_pkg::MASK_RESET;
            st_r.opc <= srs_pkg::SRS_OPC_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Answer strobes and data straight from the registered state
    assign err_clear = st_r.err_clear;
    assign out_queue_flush = st_r.flush;
    assign resp_valid = st_r.resp_valid;
    assign resp_byte = st_r.resp_byte;
    assign ident_valid = st_r.ident_valid;
    assign ident_str = st_r.ident_str;
    assign recall_valid = st_r.recall_valid;
    assign recall_state = st_r.recall_state;

    // Status summary, combinational from the registers and live inputs
    assign status_byte = sb;
    assign srq = sb[srs_pkg::SB_MSS]; // R6

endmodule

`default_nettype wire

// ---- srs_pkg.sv ----
package srs_pkg;
    // Standard event flag positions
    localparam int EV_OPC = 0;
    localparam int EV_QYE = 2;
    localparam int EV_DDE = 3;
    localparam int EV_EXE = 4;
    localparam int EV_CME = 5;
    localparam int EV_PON = 7;
    // Status summary byte positions
    localparam int SB_MAV = 4;
    localparam int SB_ESB = 5;
    localparam int SB_MSS = 6;
    localparam int SB_OSS = 7;
    // Implemented bit masks
    localparam logic [7:0] EV_IMPL_MASK = 8'hBD;
    localparam logic [7:0] SB_IMPL_MASK = 8'hF0;
    // Reset values and the completion answer
    localparam logic [7:0] EV_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] ASCII_ONE = 8'h31;
    // Common commands
    typedef enum logic [3:0] {
        SRS_CMD_NONE,
        SRS_CMD_CLS,
        SRS_CMD_EVM_WR,
        SRS_CMD_EVM_RD,
        SRS_CMD_ESR_RD,
        SRS_CMD_IDN_RD,
        SRS_CMD_OPC,
        SRS_CMD_OPC_RD,
        SRS_CMD_RCL,
        SRS_CMD_SAV,
        SRS_CMD_SQM_WR,
        SRS_CMD_SQM_RD,
        SRS_CMD_STB_RD
    } srs_cmd_e;
    typedef enum logic [1:0] {
        SRS_OPC_IDLE,
        SRS_OPC_FLAG,
        SRS_OPC_QUERY
    } srs_opc_e;
endpackage

// ---- srs_status_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module srs_status_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire srs_pkg::srs_cmd_e cmd_code,
    input wire logic cmd_nl,
    input wire logic pending_busy,
    input wire logic oper_summary,
    input wire logic out_queue_nonempty,
    input wire logic resp_valid,
    input wire logic err_clear,
    input wire logic out_queue_flush,
    input wire logic ident_valid,
    input wire logic recall_valid,
    input wire logic [7:0] status_byte
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_cmd(srs_pkg::srs_cmd_e c);
        ce && cmd_valid && cmd_code == c;
    endsequence
    property p_low; status_byte[3:0] == 4'h0; endproperty
    a_low: assert property (p_low) else $error("low bits set");
    property p_oss; status_byte[7] == oper_summary; endproperty
    a_oss: assert property (p_oss) else $error("bit7 wrong");
    property p_mav; status_byte[4] == out_queue_nonempty; endproperty
    a_mav: assert property (p_mav) else $error("bit4 wrong");
    property p_esr; s_cmd(srs_pkg::SRS_CMD_ESR_RD) |=> resp_valid; endproperty
    a_esr: assert property (p_esr) else $error("no event answer");
    property p_cls; s_cmd(srs_pkg::SRS_CMD_CLS) ##0 cmd_nl |=> err_clear && out_queue_flush; endproperty
    a_cls: assert property (p_cls) else $error("no clear");
    property p_idn; s_cmd(srs_pkg::SRS_CMD_IDN_RD) |=> ident_valid; endproperty
    a_idn: assert property (p_idn) else $error("no ident");
    property p_rcl; s_cmd(srs_pkg::SRS_CMD_RCL) |=> recall_valid; endproperty
    a_rcl: assert property (p_rcl) else $error("no recall");
    property p_opc; s_cmd(srs_pkg::SRS_CMD_OPC_RD) ##0 pending_busy |=> !resp_valid; endproperty
    a_opc: assert property (p_opc) else $error("early answer");
endmodule
bind srs_status srs_status_chk i_chk (.mclk(mclk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_nl(cmd_nl), .pending_busy(pending_busy), .oper_summary(oper_summary),
    .out_queue_nonempty(out_queue_nonempty), .resp_valid(resp_valid), .err_clear(err_clear),
    .out_queue_flush(out_queue_flush), .ident_valid(ident_valid), .recall_valid(recall_valid),
    .status_byte(status_byte));
`default_nettype wire

// ---- srs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module srs_host (
    input wire logic mclk,
    output logic cmd_valid,
    output var srs_pkg::srs_cmd_e cmd_code,
    output logic [7:0] cmd_arg,
    output logic cmd_nl
);
    initial begin
        cmd_valid = '0;
        cmd_code = srs_pkg::SRS_CMD_NONE;
        cmd_arg = '0;
        cmd_nl = '0;
    end
    // One command held across its taking edge; argument shows junk after
    task automatic send(input srs_pkg::srs_cmd_e c, input logic [7:0] a, input logic n);
        @(negedge mclk);
        cmd_valid = '1;
        cmd_code = c;
        cmd_arg = a;
        cmd_nl = n;
        @(negedge mclk);
        cmd_valid = '0;
        cmd_arg = ~a;
    endtask
endmodule
`default_nettype wire

// ---- tb_ieee4882_status_reporting.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ieee4882_status_reporting;
    typedef struct {srs_pkg::srs_cmd_e c; logic [7:0] a; logic [8:0] e;} srs_row_s;
    // Arbitrary identity strings
    localparam logic [63:0] IM = "maker_01", IO = "model_02", IS = "serial03", IV = "fwver_04";
    logic mclk = '0, rst = '1, ce = '1, busy = '0, oss = '0, mavq = '0, lost = '0;
    logic [3:0] ev = '0;
    logic [31:0] st = '0, recall_state;
    logic cmd_valid, cmd_nl, err_clear, flush, resp_valid, ident_valid, recall_valid, srq;
    srs_pkg::srs_cmd_e cmd_code;
    logic [7:0] cmd_arg, resp_byte, status_byte;
    logic [279:0] ident_str;
    int mismatches = 0, compares = 0, i, k;
    srs_row_s rows [7] = '{'{srs_pkg::SRS_CMD_ESR_RD, 8'h00, 9'h180}, '{srs_pkg::SRS_CMD_ESR_RD, 8'h00, 9'h100},
        '{srs_pkg::SRS_CMD_EVM_WR, 8'h30, 9'h000}, '{srs_pkg::SRS_CMD_EVM_RD, 8'h00, 9'h130},
        '{srs_pkg::SRS_CMD_SQM_WR, 8'h14, 9'h000}, '{srs_pkg::SRS_CMD_SQM_RD, 8'h00, 9'h114},
        '{srs_pkg::SRS_CMD_STB_RD, 8'h00, 9'h100}};
    srs_status i_dut (.mclk(mclk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg), .cmd_nl(cmd_nl), .pending_busy(busy), .oper_summary(oss), .syntax_err(ev[3]),
        .exec_err(ev[2]), .err_queue_full(ev[1]), .out_read_empty(ev[0]), .out_lost(lost), .err_present(1'b0),
        .out_queue_nonempty(mavq), .inst_state(st), .ident_mfr(IM), .ident_model(IO), .ident_serial(IS),
        .ident_fw(IV), .err_clear(err_clear), .out_queue_flush(flush), .resp_valid(resp_valid),
        .resp_byte(resp_byte), .ident_valid(ident_valid), .ident_str(ident_str), .recall_valid(recall_valid),
        .recall_state(recall_state), .status_byte(status_byte), .srq(srq));
    srs_host i_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_nl(cmd_nl));
    always #10 mclk = ~mclk;
    task automatic chk(input string n, input logic [279:0] s, input logic [279:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic ask(input srs_pkg::srs_cmd_e c, input logic [7:0] a);
        i_host.send(c, a, 1'b0);
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk) rst = '0;
        foreach (rows[j]) begin
            ask(rows[j].c, rows[j].a);
            if (rows[j].e[8]) chk("row", {resp_valid, resp_byte}, rows[j].e);
        end
        mavq = '1;
        for (i = 0; i < 5; i++) begin
            @(negedge mclk);
            ev = 4'h8 >> i;
            lost = (i == 4);
            @(negedge mclk);
            ev = '0;
            lost = '0;
            if (i == 0) begin
                chk("status", status_byte, 8'h70);
                ask(srs_pkg::SRS_CMD_STB_RD, 8'h00);
                chk("stb", {status_byte, resp_byte}, 16'h7070);
            end
            ask(srs_pkg::SRS_CMD_ESR_RD, 8'h00);
            chk("esr", resp_byte, (i < 4) ? 8'h20 >> i : 8'h04);
        end
        oss = '1;
        @(negedge mclk) chk("summary", status_byte, 8'hD0);
        chk("srq", srq, 1'b1);
        busy = '1;
        ask(srs_pkg::SRS_CMD_OPC_RD, 8'h00);
        @(negedge mclk) chk("opc wait", resp_valid, 1'b0);
        busy = '0;
        for (k = 0; k < 8 && resp_valid !== 1'b1; k++) @(negedge mclk);
        chk("opc", {resp_valid, resp_byte}, 9'h131);
        if (resp_valid !== 1'b1) give_verdict();
        busy = '1;
        ask(srs_pkg::SRS_CMD_OPC, 8'h00);
        busy = '0;
        repeat (3) @(negedge mclk);
        ask(srs_pkg::SRS_CMD_ESR_RD, 8'h00);
        chk("opc flag", resp_byte, 8'h01);
        st = 32'h1234_5678;
        ask(srs_pkg::SRS_CMD_SAV, 8'h03);
        st = 32'h9ABC_DEF0;
        ask(srs_pkg::SRS_CMD_SAV, 8'h05);
        ask(srs_pkg::SRS_CMD_RCL, 8'h03);
        chk("recall", {recall_valid, recall_state}, {1'b1, 32'h1234_5678});
        ask(srs_pkg::SRS_CMD_IDN_RD, 8'h00);
        chk("ident", {ident_valid, ident_str}, {1'b1, IM, 8'h2C, IO, 8'h2C, IS, 8'h2C, IV});
        i_host.send(srs_pkg::SRS_CMD_CLS, 8'h00, 1'b1);
        chk("cls nl", {err_clear, flush}, 2'h3);
        ask(srs_pkg::SRS_CMD_CLS, 8'h00);
        chk("cls", {err_clear, flush}, 2'h2);
        ce = '0;
        ask(srs_pkg::SRS_CMD_SQM_WR, 8'hFF);
        ce = '1;
        ask(srs_pkg::SRS_CMD_SQM_RD, 8'h00);
        chk("frozen mask", {resp_valid, resp_byte}, 9'h114);
        rst = '1;
        @(negedge mclk) rst = '0;
        chk("reset status", {srq, status_byte}, 9'h090);
        ask(srs_pkg::SRS_CMD_ESR_RD, 8'h00);
        chk("reset events", {resp_valid, resp_byte}, 9'h180);
        ask(srs_pkg::SRS_CMD_SQM_RD, 8'h00);
        chk("reset mask", {resp_valid, resp_byte}, 9'h100);
        give_verdict();
    end
endmodule
`default_nettype wire
